// ### common/bcc_pkg.sv
// shared constants and types of the brightness command block
`default_nettype none
package bcc_pkg;
    // command codes seen on the host bus
    localparam logic [7:0] CMD_WR_LUMINANCE = 8'h51;   // manual luminance write
    localparam logic [7:0] CMD_WR_CONTROL   = 8'h53;   // control byte write
    localparam logic [7:0] CMD_RD_CONTROL   = 8'h54;   // control byte readback
    localparam logic [7:0] CMD_WR_ADAPTIVE  = 8'h55;   // adaptive mode write
    localparam logic [7:0] CMD_RD_ADAPTIVE  = 8'h56;   // adaptive mode readback
    // field positions inside the control and adaptive mode bytes
    localparam int BIT_GATE      = 5;                  // brightness block enable
    localparam int BIT_DIM       = 3;                  // dimming enable
    localparam int BIT_BACKLIGHT = 2;                  // backlight enable
    localparam int MODE_MSB      = 1;                  // adaptive mode field top
    // values after reset
    localparam logic [7:0] RST_LUMINANCE = 8'h00;
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [1:0] RST_MODE      = 2'h0;
    localparam logic [7:0] LUM_MIN       = 8'h00;      // lowest brightness
    localparam logic [7:0] DUMMY_BYTE    = 8'h00;      // first read parameter
    // dimming ramp timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DIM_STEP_NS   = 100;                // time per ramp step
    localparam int DIM_STEP_CYC  = (DIM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // adaptive modes
    typedef enum logic [1:0] {
        BCC_ADAPT_OFF    = 2'h0,
        BCC_ADAPT_UI     = 2'h1,
        BCC_ADAPT_STILL  = 2'h2,
        BCC_ADAPT_MOVING = 2'h3
    } bcc_adapt_t;
    // command sequencer states, one bit apart idle -> write param, two bits idle -> read param
    typedef enum logic [1:0] {
        BCC_IDLE     = 2'h0,
        BCC_WR_PARAM = 2'h1,
        BCC_RD_PARAM = 2'h3
    } bcc_state_t;
endpackage
`default_nettype wire

// ### common/bcc_ramp_if.sv
// carrier between the command core and the luminance ramp
`timescale 1ns/1ns
`default_nettype none
interface bcc_ramp_if;
    logic [7:0] target;    // level the ramp heads for
    logic       glide;     // 1: move one step at a time
    logic [7:0] level;     // present effective luminance
    modport core (output target, output glide, input level);
    modport ramp (input target, input glide, output level);
endinterface
`default_nettype wire

// ### logic/bcc_ramp.sv
// luminance ramp: steps or jumps toward the target level
`timescale 1ns/1ns
`default_nettype none
module bcc_ramp #(
    parameter int STEP_CYC = bcc_pkg::DIM_STEP_CYC
) (
    input  wire logic sys_clk,
    input  wire logic resetn,
    bcc_ramp_if.ramp  rmp
);
    logic [15:0] tick_q;   // cycles since the pacing counter last wrapped
    logic [7:0]  level_q;  // present level

    // step pacing counter
    always_ff @(posedge sys_clk) begin
        if (!resetn || tick_q >= 16'(STEP_CYC - 1)) begin
            tick_q <= 16'h0000;
        end else begin
            tick_q <= tick_q + 16'h0001;
        end
    end

    // level follows the target, one step per tick while gliding
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            level_q <= bcc_pkg::RST_LUMINANCE;
        end else if (!rmp.glide) begin
            level_q <= rmp.target;                         // immediate change
        end else if (tick_q >= 16'(STEP_CYC - 1)) begin
            if (level_q < rmp.target) begin
                level_q <= level_q + 8'h01;
            end else if (level_q > rmp.target) begin
                level_q <= level_q - 8'h01;
            end
        end
    end

    assign rmp.level = level_q;
endmodule
`default_nettype wire

// ### logic/bcc_top.sv
// brightness command interpreter on the host command/parameter bus
// Contract
// - control write takes bits five, three, two
// - eight-bit luminance, 00h lowest, FFh highest
// - gate off forces effective level 00h
// - gate on uses stored luminance level
// - dimming bit on/off, manual brightness only
// - backlight bit switches backlight control
// - gate toggle with dimming ramps gradually
// - backlight off acts at once, no ramp
// - control readback: dummy, then control bits
// - mode write takes bits one to zero
// - mode off, ui, still, moving
// - mode readback: dummy, then mode bits
// - serial skips dummy, parallel needs dummy
// - commands accepted in every power state
`timescale 1ns/1ns
`default_nettype none
module bcc_top #(
    parameter int STEP_CYC = bcc_pkg::DIM_STEP_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       cmd_data_select,
    input  wire logic       write_strobe_n,
    input  wire logic       read_strobe_n,
    input  wire logic       host_port_select,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    output logic      [7:0] luminance_out,
    output logic            brightness_gate_on,
    output logic            dimming_on,
    output logic            backlight_on,
    output logic      [1:0] adaptive_mode
);
    // pin synchronisers, first stage read only by the second
    logic [7:0] din_s1_q, din_s2_q;            // data bus
    logic       dcs_s1_q, dcs_s2_q;            // command/data select
    logic       wr_s1_q,  wr_s2_q, wr_s3_q;    // write strobe, s3 for edges
    logic       rd_s1_q,  rd_s2_q, rd_s3_q;    // read strobe, s3 for edges
    logic       psel_s1_q, psel_s2_q;          // port select

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            din_s1_q  <= 8'h00;
            din_s2_q  <= 8'h00;
            dcs_s1_q  <= 1'b0;
            dcs_s2_q  <= 1'b0;
            wr_s1_q   <= 1'b1;
            wr_s2_q   <= 1'b1;
            wr_s3_q   <= 1'b1;
            rd_s1_q   <= 1'b1;
            rd_s2_q   <= 1'b1;
            rd_s3_q   <= 1'b1;
            psel_s1_q <= 1'b0;
            psel_s2_q <= 1'b0;
        end else begin
            din_s1_q  <= data_in;
            din_s2_q  <= din_s1_q;
            dcs_s1_q  <= cmd_data_select;
            dcs_s2_q  <= dcs_s1_q;
            wr_s1_q   <= write_strobe_n;
            wr_s2_q   <= wr_s1_q;
            wr_s3_q   <= wr_s2_q;
            rd_s1_q   <= read_strobe_n;
            rd_s2_q   <= rd_s1_q;
            rd_s3_q   <= rd_s2_q;
            psel_s1_q <= host_port_select;
            psel_s2_q <= psel_s1_q;
        end
    end

    // strobe edges: bytes are taken on the rising edge
    logic wr_rise, rd_rise, rd_fall;
    assign wr_rise = wr_s2_q & ~wr_s3_q;
    assign rd_rise = rd_s2_q & ~rd_s3_q;
    assign rd_fall = ~rd_s2_q & rd_s3_q;

    // packs the control readback byte
    function automatic logic [7:0] pack_ctrl(input logic g, input logic d, input logic b);
        logic [7:0] v;
        v = 8'h00;
        v[bcc_pkg::BIT_GATE]      = g;
        v[bcc_pkg::BIT_DIM]       = d;
        v[bcc_pkg::BIT_BACKLIGHT] = b;
        return v;
    endfunction

    // state held by the block
    bcc_pkg::bcc_state_t state_q;      // sequencer state
    logic [7:0] cmd_q;                 // last command code
    logic       rd_seen_q;             // one read of this command done
    logic [7:0] lum_q;                 // stored manual luminance
    logic       gate_q, dim_q, bl_q;   // control byte fields
    logic [1:0] mode_q;                // adaptive mode field
    logic       glide_q;               // ramp in progress
    logic [7:0] dout_q;                // read data pins
    logic       doe_q;                 // read data enable

    bcc_ramp_if rif ();

    // command sequencer; no power state gates it
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q <= bcc_pkg::BCC_IDLE;
            cmd_q   <= 8'h00;
        end else if (wr_rise && !dcs_s2_q) begin
            cmd_q <= din_s2_q;
            case (din_s2_q)
                bcc_pkg::CMD_WR_LUMINANCE,
                bcc_pkg::CMD_WR_CONTROL,
                bcc_pkg::CMD_WR_ADAPTIVE: state_q <= bcc_pkg::BCC_WR_PARAM;
                bcc_pkg::CMD_RD_CONTROL,
                bcc_pkg::CMD_RD_ADAPTIVE: state_q <= bcc_pkg::BCC_RD_PARAM;
                default:                  state_q <= bcc_pkg::BCC_IDLE;
            endcase
        end else if (wr_rise && state_q == bcc_pkg::BCC_WR_PARAM) begin
            state_q <= bcc_pkg::BCC_IDLE;                             // one parameter only
        end
    end

    // read progress: counts the dummy read on the parallel port
    always_ff @(posedge sys_clk) begin
        if (!resetn || (wr_rise && !dcs_s2_q)) begin
            rd_seen_q <= 1'b0;
        end else if (rd_rise && state_q == bcc_pkg::BCC_RD_PARAM) begin
            rd_seen_q <= 1'b1;
        end
    end

    // parameter writes into the settings
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            lum_q  <= bcc_pkg::RST_LUMINANCE;
            gate_q <= bcc_pkg::RST_BYTE[bcc_pkg::BIT_GATE];
            dim_q  <= bcc_pkg::RST_BYTE[bcc_pkg::BIT_DIM];
            bl_q   <= bcc_pkg::RST_BYTE[bcc_pkg::BIT_BACKLIGHT];
            mode_q <= bcc_pkg::RST_MODE;
        end else if (wr_rise && dcs_s2_q && state_q == bcc_pkg::BCC_WR_PARAM) begin
            case (cmd_q)
                bcc_pkg::CMD_WR_LUMINANCE: lum_q <= din_s2_q;
                bcc_pkg::CMD_WR_CONTROL: begin
                    gate_q <= din_s2_q[bcc_pkg::BIT_GATE];
                    dim_q  <= din_s2_q[bcc_pkg::BIT_DIM];
                    bl_q   <= din_s2_q[bcc_pkg::BIT_BACKLIGHT];
                end
                bcc_pkg::CMD_WR_ADAPTIVE: mode_q <= din_s2_q[bcc_pkg::MODE_MSB:0];
                default: ;
            endcase
        end
    end

    // ramp request: gate toggled with dimming on, manual mode only
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            glide_q <= 1'b0;
        end else if (wr_rise && dcs_s2_q && state_q == bcc_pkg::BCC_WR_PARAM
                     && cmd_q == bcc_pkg::CMD_WR_CONTROL
                     && din_s2_q[bcc_pkg::BIT_GATE] != gate_q) begin
            glide_q <= din_s2_q[bcc_pkg::BIT_DIM]
                       && mode_q == bcc_pkg::BCC_ADAPT_OFF;
        end else if (rif.level == rif.target) begin
            glide_q <= 1'b0;                                          // target reached
        end
    end

    // effective target level: gate off forces the lowest value
    assign rif.target = gate_q ? lum_q : bcc_pkg::LUM_MIN;
    assign rif.glide  = glide_q;

    bcc_ramp #(.STEP_CYC(STEP_CYC)) u_ramp (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .rmp     (rif)
    );

    // read data: dummy first on parallel, payload at once on serial
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            dout_q <= 8'h00;
            doe_q  <= 1'b0;
        end else if (rd_fall && state_q == bcc_pkg::BCC_RD_PARAM) begin
            doe_q <= 1'b1;
            if (psel_s2_q && !rd_seen_q) begin
                dout_q <= bcc_pkg::DUMMY_BYTE;
            end else if (cmd_q == bcc_pkg::CMD_RD_CONTROL) begin
                dout_q <= pack_ctrl(gate_q, dim_q, bl_q);
            end else begin
                dout_q <= {6'h00, mode_q};
            end
        end else if (rd_rise) begin
            doe_q <= 1'b0;
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            brightness_gate_on <= 1'b0;
            dimming_on         <= 1'b0;
            backlight_on       <= 1'b0;
            adaptive_mode      <= bcc_pkg::RST_MODE;
        end else begin
            brightness_gate_on <= gate_q;
            dimming_on         <= dim_q;
            backlight_on       <= bl_q;
            adaptive_mode      <= mode_q;
        end
    end

    assign luminance_out = rif.level;   // flop inside the ramp
    assign data_out      = dout_q;
    assign data_oe       = doe_q;
endmodule
`default_nettype wire

// ### verification/bcc_chk.sv
// assertion checker for the brightness command block
`timescale 1ns/1ns
`default_nettype none
module bcc_chk #(parameter int STEP_CYC = 2) (
    input wire logic       sys_clk,
    input wire logic       resetn,
    input wire logic       cmd_data_select,
    input wire logic       write_strobe_n,
    input wire logic       read_strobe_n,
    input wire logic       host_port_select,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic       data_oe,
    input wire logic [7:0] luminance_out,
    input wire logic       brightness_gate_on,
    input wire logic       dimming_on,
    input wire logic       backlight_on,
    input wire logic [1:0] adaptive_mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    reset_clear_a: assert property ($rose(resetn) |-> {brightness_gate_on, dimming_on, backlight_on,
        adaptive_mode, data_oe} == 6'h00) else $error("state not cleared by reset");
    mode_source_a: assert property ($changed(adaptive_mode) |-> $past(cmd_data_select, 4)
        && adaptive_mode == $past(data_in[1:0], 4)) else $error("mode not from parameter bits");
    gate_source_a: assert property ($changed(brightness_gate_on)
        |-> brightness_gate_on == $past(data_in[5], 4)) else $error("gate not from bit five");
    dim_source_a: assert property ($changed(dimming_on) |-> dimming_on == $past(data_in[3], 4))
        else $error("dimming not from bit three");
    light_source_a: assert property ($changed(backlight_on) |-> backlight_on == $past(data_in[2], 4))
        else $error("backlight not from bit two");
    oe_start_a: assert property ($rose(data_oe) |-> !$past(read_strobe_n, 2) || !$past(read_strobe_n, 3))
        else $error("drive without read strobe");
    oe_end_a: assert property ($fell(data_oe) |-> $past(read_strobe_n, 2) || $past(read_strobe_n, 3))
        else $error("drive dropped during read");
    glide_slope_a: assert property ($rose(brightness_gate_on) && dimming_on && adaptive_mode == 2'h0
        |-> (luminance_out <= 8'h02) [*3]) else $error("level jumped while dimming");
    gate_off_zero_a: assert property ((!brightness_gate_on && !dimming_on) [*4]
        |-> luminance_out == 8'h00) else $error("level not zero with gate off");
endmodule
bind bcc_top bcc_chk #(.STEP_CYC(STEP_CYC)) bcc_chk_i (.sys_clk(sys_clk), .resetn(resetn),
    .cmd_data_select(cmd_data_select), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .host_port_select(host_port_select), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .luminance_out(luminance_out), .brightness_gate_on(brightness_gate_on), .dimming_on(dimming_on),
    .backlight_on(backlight_on), .adaptive_mode(adaptive_mode));
`default_nettype wire

// ### verification/bcc_host.sv
// host model driving command and parameter bytes
`timescale 1ns/1ns
`default_nettype none
module bcc_host (
    input  wire logic       sys_clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output logic            cmd_data_select,
    output logic            write_strobe_n,
    output logic            read_strobe_n,
    output logic      [7:0] data_in
);
    // idle bus from time zero
    initial begin
        cmd_data_select = 1'b0;
        write_strobe_n = 1'b1;
        read_strobe_n = 1'b1;
        data_in = 8'h00;
    end
    // one byte, held six cycles around the rising strobe
    task automatic wr(input logic dcs, input logic [7:0] b);
        @(posedge sys_clk) #1;
        cmd_data_select = dcs;
        data_in = b;
        write_strobe_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1 write_strobe_n = 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask
    // one read cycle; bus byte inverted so no stale value lingers
    // an undriven read bus is returned as unknown so it never matches
    task automatic rd(output logic [7:0] b);
        @(posedge sys_clk) #1;
        cmd_data_select = 1'b1;
        data_in = ~data_in;
        read_strobe_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        b = data_oe ? data_out : 8'hXX;
        #1 read_strobe_n = 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ### verification/brightness_ctrl_commands_tb_top.sv
// self-checking bench for the brightness command block
`timescale 1ns/1ns
`default_nettype none
module brightness_ctrl_commands_tb_top;
    logic       sys_clk, resetn, psel, dcs, wr_n, rd_n, oe, gate, dim, bl;
    logic [7:0] din, dout, lum, v;
    logic [1:0] mode;
    int         error_cnt = 0;
    int         compares = 0;
    bcc_top #(.STEP_CYC(2)) bcc_top_i (.sys_clk(sys_clk), .resetn(resetn), .cmd_data_select(dcs),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n), .host_port_select(psel), .data_in(din),
        .data_out(dout), .data_oe(oe), .luminance_out(lum), .brightness_gate_on(gate),
        .dimming_on(dim), .backlight_on(bl), .adaptive_mode(mode));
    bcc_host bcc_host_i (.sys_clk(sys_clk), .data_out(dout), .data_oe(oe), .cmd_data_select(dcs),
        .write_strobe_n(wr_n), .read_strobe_n(rd_n), .data_in(din));
    // free running clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // byte comparison
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // command then dummy (parallel only) and payload
    task automatic rd_reg(input logic [7:0] c, output logic [7:0] r);
        logic [7:0] d;
        bcc_host_i.wr(1'b0, c);
        if (psel) begin
            bcc_host_i.rd(d);
            chk("dummy byte", 8'h00, d);
        end
        bcc_host_i.rd(r);
    endtask
    // bounded wait for the level
    task automatic wait_lum(input logic [7:0] exp);
        int n;
        n = 0;
        while (lum !== exp && n < 600) begin
            @(posedge sys_clk) #1;
            n++;
        end
        chk("luminance", exp, lum);
    endtask
    // reset and cleared values
    task automatic t_reset;
        @(posedge sys_clk) #1 resetn = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1 resetn = 1'b1;
        psel = 1'b1;
        chk("control bits", 8'h00, {2'h0, gate, 1'b0, dim, bl, 2'h0});
        rd_reg(bcc_pkg::CMD_RD_CONTROL, v);
        chk("control readback", 8'h00, v);
        rd_reg(bcc_pkg::CMD_RD_ADAPTIVE, v);
        chk("mode readback", 8'h00, v);
        $display("reset test done");
    endtask
    // gate, dimming and backlight
    task automatic t_control;
        bcc_host_i.wr(1'b0, 8'h51);
        bcc_host_i.wr(1'b1, 8'hFF);
        chk("gated level", 8'h00, lum);
        bcc_host_i.wr(1'b0, 8'h53);
        bcc_host_i.wr(1'b1, 8'h24);
        wait_lum(8'hFF);
        bcc_host_i.wr(1'b0, 8'h53);
        bcc_host_i.wr(1'b1, 8'hFF);
        chk("control bits", 8'h2C, {2'h0, gate, 1'b0, dim, bl, 2'h0});
        rd_reg(bcc_pkg::CMD_RD_CONTROL, v);
        chk("control readback", 8'h2C, v);
        bcc_host_i.wr(1'b0, 8'h51);
        bcc_host_i.wr(1'b1, 8'h40);
        wait_lum(8'h40);
        bcc_host_i.wr(1'b0, 8'h53);
        bcc_host_i.wr(1'b1, 8'h08);
        chk("backlight", 8'h00, {7'h0, bl});
        chk("ramp under way", 8'h01, {7'h0, lum > 8'h00});
        wait_lum(8'h00);
        bcc_host_i.wr(1'b0, 8'h53);
        bcc_host_i.wr(1'b1, 8'h2C);
        wait_lum(8'h40);
        bcc_host_i.wr(1'b0, 8'h53);
        bcc_host_i.wr(1'b1, 8'h04);
        wait_lum(8'h00);
        $display("control test done");
    endtask
    // every adaptive mode over the serial port
    task automatic t_mode;
        @(posedge sys_clk) #1 psel = 1'b0;
        for (int i = 3; i >= 0; i--) begin
            bcc_host_i.wr(1'b0, 8'h55);
            bcc_host_i.wr(1'b1, 8'hFC | 8'(i));
            chk("mode", 8'(i), {6'h0, mode});
            rd_reg(bcc_pkg::CMD_RD_ADAPTIVE, v);
            chk("mode readback", 8'(i), v);
        end
        bcc_host_i.wr(1'b0, 8'h55);
        bcc_host_i.wr(1'b1, 8'h01);
        bcc_host_i.wr(1'b1, 8'h03);
        chk("extra parameter", 8'h01, {6'h0, mode});
        rd_reg(bcc_pkg::CMD_RD_CONTROL, v);
        chk("serial control readback", 8'h04, v);
        // gate on with dimming while adaptive mode runs: level jumps
        bcc_host_i.wr(1'b0, 8'h53);
        bcc_host_i.wr(1'b1, 8'h2C);
        chk("adaptive jump", 8'h40, lum);
        $display("mode test done");
    endtask
    // main sequence
    initial begin
        resetn = 1'b0;
        psel = 1'b1;
        t_reset();
        t_control();
        t_mode();
        t_reset();
        report_and_stop();
    end
    // hang guard
    initial begin
        #300000;
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
